// ==== design/motor_param_pkg.sv ====
// Constants, types and the code expansion function for the motor parameter decoder.
// Assumes one 10 MHz core clock with a synchronous active-high reset.
// How it works
// - The phase-resistance setting is a 7-bit code whose linear value counts in steps of 7.35 milliohm.
// - The phase-resistance code expands as its low four bits shifted left by its upper three bits.
// - The all-ones phase-resistance code expands to 1920, about 14.1 ohm.
// - The back-EMF code expands in the same way, mantissa in the low four bits shifted by the upper three.
// - The all-ones back-EMF code expands to 1920, meaning 1330 mV/Hz.
// - The back-EMF code 0x01 expands to 1, meaning 0.7 mV/Hz.
// - Start-up tells stationary, forward-spinning and reverse-spinning motors apart and takes a path for each.
// - The phase-resistance code lives in the first parameter register and the back-EMF code in the second.
package motor_param_pkg;

	localparam int unsigned CODE_W      = 7;
	localparam int unsigned LIN_W       = 11;
	localparam int unsigned MANT_LSB    = 0;
	localparam int unsigned MANT_W      = 4;
	localparam int unsigned EXP_LSB     = 4;
	localparam int unsigned EXP_W       = 3;
	localparam int unsigned MANT_TOP    = 3;

	localparam logic [CODE_W-1:0] CODE_RST     = 7'h00;
	localparam logic [CODE_W-1:0] CODE_ALL_ONE = 7'h7f;
	localparam logic [CODE_W-1:0] CODE_MIN_KT  = 7'h01;
	localparam logic [LIN_W-1:0]  LIN_RST      = 11'h000;
	localparam logic [LIN_W-1:0]  LIN_MAX      = 11'h780;
	localparam logic [LIN_W-1:0]  LIN_MIN_RES  = 11'h004;
	localparam logic [LIN_W-1:0]  LIN_MIN_KT   = 11'h001;

	// Scale of one linear step: resistance in micro-ohm, back-EMF weight per V/Hz
	localparam int unsigned RES_STEP_UOHM  = 7350;
	localparam int unsigned KT_WEIGHT      = 1442;

	typedef struct packed {
		logic              wr_one;
		logic              wr_two;
		logic [CODE_W-1:0] data;
	} param_write_t;

	typedef struct packed {
		logic start_req;
		logic spinning;
		logic reverse;
	} motion_sense_t;

	typedef enum logic [1:0] {
		COND_NONE,
		COND_STATIONARY,
		COND_FORWARD,
		COND_REVERSE
	} start_path_t;

	function automatic logic [LIN_W-1:0] expand_code(input logic [CODE_W-1:0] code);
		logic [LIN_W-1:0] mant;
		mant = {7'h00, code[MANT_LSB +: MANT_W]};
		return mant << code[EXP_LSB +: EXP_W];
	endfunction

endpackage

// ==== design/motor_param_code_decoder.sv ====
// Holds the two motor parameter codes and expands them to linear values; classifies the start condition.
// Assumes write strobes and motion sense come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module motor_param_code_decoder
(
	input  wire logic                                     clk,
	input  wire logic                                     srst,
	input  wire motor_param_pkg::param_write_t            param_wr,
	input  wire motor_param_pkg::motion_sense_t           motion,
	output var  logic [motor_param_pkg::CODE_W-1:0]       phase_resistance_code_q,
	output var  logic [motor_param_pkg::CODE_W-1:0]       bemf_constant_code_q,
	output var  logic [motor_param_pkg::LIN_W-1:0]        phase_res_linear_q,
	output var  logic [motor_param_pkg::LIN_W-1:0]        bemf_linear_q,
	output var  logic                                     res_below_min_q,
	output var  logic [1:0]                               not_normalised_q,
	output var  motor_param_pkg::start_path_t             start_path_q,
	output var  logic                                     start_path_valid_q
);
	import motor_param_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Parameter registers
	logic [CODE_W-1:0] phase_resistance_code_d;
	logic [CODE_W-1:0] bemf_constant_code_d;

	always_comb
	begin
		phase_resistance_code_d = phase_resistance_code_q;
		bemf_constant_code_d    = bemf_constant_code_q;
		if (param_wr.wr_one)
		begin
			phase_resistance_code_d = param_wr.data;
		end
		if (param_wr.wr_two)
		begin
			bemf_constant_code_d = param_wr.data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			phase_resistance_code_q <= CODE_RST;
			bemf_constant_code_q    <= CODE_RST;
		end
		else
		begin
			phase_resistance_code_q <= phase_resistance_code_d;
			bemf_constant_code_q    <= bemf_constant_code_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Code expansion, one channel per parameter
	logic [CODE_W-1:0] code_sel [2];
	logic [LIN_W-1:0]  lin_d    [2];
	logic [LIN_W-1:0]  lin_q    [2];
	logic [1:0]        norm_d;

	assign code_sel[0] = phase_resistance_code_q;
	assign code_sel[1] = bemf_constant_code_q;

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		always_comb
		begin
			lin_d[ch]  = expand_code(code_sel[ch]);
			// Flags a code with exponent but no mantissa top bit
			norm_d[ch] = (code_sel[ch][EXP_LSB +: EXP_W] != 3'h0) && !code_sel[ch][MANT_TOP];
		end

		always_ff @(posedge clk)
		begin
			if (srst)
			begin
				lin_q[ch] <= LIN_RST;
			end
			else
			begin
				lin_q[ch] <= lin_d[ch];
			end
		end
	end

	logic res_below_min_d;

	always_comb
	begin
		// low resistance warning, code zero is a legal zero
		res_below_min_d = (lin_d[0] != LIN_RST) && (lin_d[0] < LIN_MIN_RES);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			res_below_min_q  <= 1'b0;
			not_normalised_q <= 2'h0;
		end
		else
		begin
			res_below_min_q  <= res_below_min_d;
			not_normalised_q <= norm_d;
		end
	end

	assign phase_res_linear_q = lin_q[0];
	assign bemf_linear_q      = lin_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Start condition classification
	start_path_t start_path_d;
	logic        start_path_valid_d;

	always_comb
	begin
		start_path_d       = start_path_q;
		start_path_valid_d = 1'b0;
		if (motion.start_req)
		begin
			start_path_valid_d = 1'b1;
			case ({motion.spinning, motion.reverse})
				2'b10:   start_path_d = COND_FORWARD;
				2'b11:   start_path_d = COND_REVERSE;
				default: start_path_d = COND_STATIONARY;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			start_path_q       <= COND_NONE;
			start_path_valid_q <= 1'b0;
		end
		else
		begin
			start_path_q       <= start_path_d;
			start_path_valid_q <= start_path_valid_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_res_expand;
		logic [CODE_W-1:0] c;
		@(posedge clk) disable iff (srst)
		(param_wr.wr_one, c = param_wr.data) |-> ##2 phase_res_linear_q == expand_code(c);
	endproperty
	a_res_expand: assert property (p_res_expand) else $error("phase resistance expansion wrong");

	property p_res_max;
		@(posedge clk) disable iff (srst)
		(param_wr.wr_one && param_wr.data == CODE_ALL_ONE) |-> ##2 phase_res_linear_q == LIN_MAX;
	endproperty
	a_res_max: assert property (p_res_max) else $error("all-ones resistance code not 1920");

	// First edge after reset sees the code from before reset, so it is skipped
	property p_res_bound;
		@(posedge clk) disable iff (srst)
		!$past(srst) |-> phase_res_linear_q <= LIN_MAX
			&& phase_res_linear_q == (LIN_W'($past(phase_resistance_code_q[MANT_LSB +: MANT_W]))
				<< $past(phase_resistance_code_q[EXP_LSB +: EXP_W]));
	endproperty
	a_res_bound: assert property (p_res_bound) else $error("resistance linear value off its code");

	property p_kt_expand;
		logic [CODE_W-1:0] c;
		@(posedge clk) disable iff (srst)
		(param_wr.wr_two, c = param_wr.data) |-> ##2 bemf_linear_q == expand_code(c);
	endproperty
	a_kt_expand: assert property (p_kt_expand) else $error("back-EMF expansion wrong");

	property p_kt_max;
		@(posedge clk) disable iff (srst)
		(param_wr.wr_two && param_wr.data == CODE_ALL_ONE) |-> ##2 bemf_linear_q == LIN_MAX;
	endproperty
	a_kt_max: assert property (p_kt_max) else $error("all-ones back-EMF code not 1920");

	property p_kt_min;
		@(posedge clk) disable iff (srst)
		(param_wr.wr_two && param_wr.data == CODE_MIN_KT) |-> ##2 bemf_linear_q == LIN_MIN_KT;
	endproperty
	a_kt_min: assert property (p_kt_min) else $error("back-EMF code 0x01 not 1");

	property p_reg_sep;
		@(posedge clk) disable iff (srst)
		(param_wr.wr_two && !param_wr.wr_one) |=> $stable(phase_resistance_code_q)
			&& bemf_constant_code_q == $past(param_wr.data);
	endproperty
	a_reg_sep: assert property (p_reg_sep) else $error("parameter register written in wrong place");

	property p_path;
		@(posedge clk) disable iff (srst)
		motion.start_req |=> start_path_valid_q && start_path_q ==
			(!$past(motion.spinning) ? COND_STATIONARY : ($past(motion.reverse) ? COND_REVERSE : COND_FORWARD));
	endproperty
	a_path: assert property (p_path) else $error("start path misclassified");

	property p_path_quiet;
		@(posedge clk) disable iff (srst)
		!motion.start_req ##1 !motion.start_req |-> !start_path_valid_q ##1 $stable(start_path_q);
	endproperty
	a_path_quiet: assert property (p_path_quiet) else $error("start path changed without request");

	property p_res_low;
		@(posedge clk) disable iff (srst)
		(param_wr.wr_one && param_wr.data inside {7'h01, 7'h02, 7'h03}) |-> ##2 res_below_min_q;
	endproperty
	a_res_low: assert property (p_res_low) else $error("low resistance warning missing");

	c_res_max:   cover property (@(posedge clk) disable iff (srst) phase_res_linear_q == LIN_MAX);
	c_kt_min:    cover property (@(posedge clk) disable iff (srst) bemf_linear_q == LIN_MIN_KT);
	c_reverse:   cover property (@(posedge clk) disable iff (srst) start_path_valid_q && start_path_q == COND_REVERSE);
	c_forward:   cover property (@(posedge clk) disable iff (srst) start_path_valid_q && start_path_q == COND_FORWARD);

endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the motor parameter code decoder.
// Assumes one 100 ns clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import motor_param_pkg::*;

	logic                clk;
	logic                srst;
	param_write_t        param_wr;
	motion_sense_t       motion;
	logic [CODE_W-1:0]   res_code;
	logic [CODE_W-1:0]   kt_code;
	logic [LIN_W-1:0]    res_lin;
	logic [LIN_W-1:0]    kt_lin;
	logic                res_low;
	logic [1:0]          not_norm;
	start_path_t         start_path_q;
	logic                start_path_valid_q;
	int                  failures;
	int                  n_compared;
	int                  cycles;
	logic [CODE_W-1:0]   exp_res;
	logic [CODE_W-1:0]   exp_kt;

	motor_param_code_decoder dut
	(
		.clk                     (clk),
		.srst                    (srst),
		.param_wr                (param_wr),
		.motion                  (motion),
		.phase_resistance_code_q (res_code),
		.bemf_constant_code_q    (kt_code),
		.phase_res_linear_q      (res_lin),
		.bemf_linear_q           (kt_lin),
		.res_below_min_q         (res_low),
		.not_normalised_q        (not_norm),
		.start_path_q            (start_path_q),
		.start_path_valid_q      (start_path_valid_q)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [10:0] lin(input logic [6:0] c);
		logic [10:0] m;
		m = {7'h00, c[3:0]};
		return m << c[6:4];
	endfunction

	task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Write one or both registers, check code, then linear value and flags
	task automatic wr(input logic one, input logic two, input logic [6:0] d);
		logic [6:0] r;
		logic [6:0] k;
		@(negedge clk);
		param_wr = '{one, two, d};
		@(negedge clk);
		param_wr = '0;
		if (one)
			exp_res = d;
		if (two)
			exp_kt = d;
		r = exp_res;
		k = exp_kt;
		chk({4'h0, res_code}, {4'h0, r}, "res code");
		chk({4'h0, kt_code}, {4'h0, k}, "bemf code");
		@(negedge clk);
		chk(res_lin, lin(r), "res linear");
		chk(kt_lin, lin(k), "bemf linear");
		chk({10'h0, res_low}, {10'h0, lin(r) inside {[1:3]}}, "res low");
		chk({9'h0, not_norm}, {9'h0, k[6:4] != 3'h0 && !k[3], r[6:4] != 3'h0 && !r[3]}, "norm");
	endtask

	task automatic sp(input logic v, input start_path_t p);
		chk({10'h0, start_path_valid_q}, {10'h0, v}, "valid");
		chk({9'h0, start_path_q}, {9'h0, p}, "path");
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic test_codes;
		logic [6:0] rc [10] = '{7'h7f, 7'h00, 7'h01, 7'h03, 7'h04, 7'h28, 7'h5f, 7'h10, 7'h2f, 7'h68};
		logic [6:0] kc [6] = '{7'h01, 7'h7f, 7'h4f, 7'h20, 7'h3a, 7'h00};
		foreach (rc[i]) wr(1'b1, 1'b0, rc[i]);
		foreach (kc[i]) wr(1'b0, 1'b1, kc[i]);
		wr(1'b1, 1'b1, 7'h7f);
		chk(res_lin, 11'h780, "res max");
		chk(kt_lin, 11'h780, "bemf max");
		// Largest code in tenths of an ohm
		chk(11'((res_lin * RES_STEP_UOHM) / 100000), 11'h08d, "res ohm");
		$display("test_codes done");
	endtask

	// Writes on consecutive cycles land in their own registers
	task automatic test_b2b;
		@(negedge clk);
		param_wr = '{1'b1, 1'b0, 7'h01};
		@(negedge clk);
		param_wr = '{1'b0, 1'b1, 7'h01};
		@(negedge clk);
		param_wr = '0;
		exp_res = 7'h01;
		exp_kt  = 7'h01;
		@(negedge clk);
		chk(res_lin, 11'h001, "b2b res");
		chk(kt_lin, 11'h001, "b2b bemf");
		// 0.7 mV/Hz weighted and rounded to a linear step
		chk(kt_lin, 11'((7 * KT_WEIGHT + 5000) / 10000), "b2b bemf weight");
		chk({10'h0, res_low}, 11'h001, "b2b low");
		$display("test_b2b done");
	endtask

	task automatic test_start;
		@(negedge clk);
		motion = '{1'b1, 1'b0, 1'b1};
		@(negedge clk);
		motion = '{1'b1, 1'b1, 1'b0};
		sp(1'b1, COND_STATIONARY);
		@(negedge clk);
		motion = '{1'b1, 1'b1, 1'b1};
		sp(1'b1, COND_FORWARD);
		@(negedge clk);
		motion = '0;
		sp(1'b1, COND_REVERSE);
		@(negedge clk);
		sp(1'b0, COND_REVERSE);
		$display("test_start done");
	endtask

	task automatic test_reset;
		wr(1'b1, 1'b1, 7'h55);
		@(negedge clk);
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		exp_res = CODE_RST;
		exp_kt  = CODE_RST;
		chk({4'h0, res_code}, {4'h0, exp_res}, "rst res code");
		chk({4'h0, kt_code}, {4'h0, exp_kt}, "rst bemf code");
		chk(res_lin | kt_lin, 11'h000, "rst linear");
		chk({10'h0, res_low}, 11'h000, "rst low");
		chk({9'h0, not_norm}, 11'h000, "rst norm");
		sp(1'b0, COND_NONE);
		@(negedge clk);
		chk(res_lin | kt_lin, 11'h000, "rst linear held");
		wr(1'b0, 1'b1, 7'h4f);
		$display("test_reset done");
	endtask

	task automatic results;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			$display("[FAIL] %0t timeout", $time);
			results();
		end
	end

	initial
	begin
		failures = 0;
		n_compared = 0;
		cycles = 0;
		srst = 1'b1;
		param_wr = '0;
		motion = '0;
		exp_res = 7'h00;
		exp_kt = 7'h00;
		repeat (5) @(negedge clk);
		srst = 1'b0;
		sp(1'b0, COND_NONE);
		test_codes();
		test_b2b();
		test_start();
		test_reset();
		results();
	end
endmodule
`default_nettype wire
